//--- include/dec_pkg.sv
package dec_pkg;

    // ****************************************************
    // Register indices; byte address is four times these
    // ****************************************************
    localparam logic [3:0] DEC_IDX_OUTPUT_CONTROL = 4'h1;
    localparam logic [3:0] DEC_IDX_EVENT_CONTROL = 4'h2;
    localparam logic [3:0] DEC_IDX_INT_ENABLE_CLEAR = 4'h4;
    localparam logic [3:0] DEC_IDX_INT_ENABLE_SET = 4'h5;
    localparam logic [3:0] DEC_IDX_INT_FLAGS = 4'h6;
    localparam logic [3:0] DEC_IDX_SYNC_STATUS = 4'h7;
    localparam logic [3:0] DEC_IDX_DATA = 4'h8;
    localparam logic [3:0] DEC_IDX_SAMPLE_BUFFER = 4'hc;

    // ****************************************************
    // Field positions
    // ****************************************************
    localparam int DEC_BIT_EXT_OUT = 0;
    localparam int DEC_BIT_INT_OUT = 1;
    localparam int DEC_BIT_LEFT = 2;
    localparam int DEC_BIT_START_IN = 0;
    localparam int DEC_BIT_EMPTY_OUT = 1;
    localparam int DEC_BIT_UNDERRUN = 0;
    localparam int DEC_BIT_EMPTY = 1;
    localparam int DEC_BIT_SYNC_READY = 2;
    localparam int DEC_BIT_SYNC_BUSY = 7;
    localparam int DEC_RIGHT_LSB = 0;
    localparam int DEC_LEFT_LSB = 6;

    // ****************************************************
    // Reset values and writable masks
    // ****************************************************
    localparam logic [7:0] DEC_RST_BYTE = 8'h00;
    localparam logic [15:0] DEC_RST_WORD = 16'h0000;
    localparam logic [2:0] DEC_OUTCTL_MASK = 3'h7;
    localparam logic [1:0] DEC_EVCTL_MASK = 2'h3;
    localparam logic [2:0] DEC_INT_MASK = 3'h7;

    // ****************************************************
    // Timing: clock-domain crossing time in bus cycles
    // ****************************************************
    localparam int DEC_SYNC_CYCLES = 4;

    // Synchroniser tracker states
    typedef enum logic [0:0] {
        DEC_SYNC_IDLE = 1'b0,
        DEC_SYNC_BUSY = 1'b1
    } dec_sync_state_type;

endpackage : dec_pkg

//--- rtl/dec_wb_slave.sv
`timescale 1ns/1ps
module dec_wb_slave
    import dec_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone request
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    // Decoded strobes
    output logic ack_o,
    output logic wr_stb_o,
    output logic rd_stb_o,
    output logic [3:0] idx_o
);

    // ****************************************************
    // Acknowledge state
    // ****************************************************
    typedef struct packed {
        logic ack;
    } dec_wb_state_type;

    dec_wb_state_type st_q;
    dec_wb_state_type st_d;
    logic req;

    // One wait state, then ack for exactly one cycle
    always_comb begin
        req = cyc_i & stb_i;
        st_d = st_q;
        st_d.ack = req & ~st_q.ack;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Writes land on the ack edge; reads sample the cycle before
    assign ack_o = st_q.ack;
    assign wr_stb_o = req & we_i & st_q.ack;
    assign rd_stb_o = req & ~we_i & ~st_q.ack;
    assign idx_o = adr_i[5:2];

endmodule : dec_wb_slave

//--- rtl/dec_sync_tracker.sv
`timescale 1ns/1ps
module dec_sync_tracker
    import dec_pkg::*;
#(
    parameter int SYNC_CYCLES = DEC_SYNC_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Handshake
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);

    typedef struct packed {
        dec_sync_state_type state;
        logic [7:0] cnt;
        logic done;
    } dec_trk_state_type;

    dec_trk_state_type st_q;
    dec_trk_state_type st_d;

    // Models the crossing delay; a new start restarts the count
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        case (st_q.state)
            DEC_SYNC_IDLE: begin
                if (start_i) begin
                    st_d.state = DEC_SYNC_BUSY;
                    st_d.cnt = 8'(SYNC_CYCLES - 1);
                end
            end
            DEC_SYNC_BUSY: begin
                if (start_i) begin
                    st_d.cnt = 8'(SYNC_CYCLES - 1);
                end else if (st_q.cnt == 8'h00) begin
                    st_d.state = DEC_SYNC_IDLE;
                    st_d.done = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt - 8'h01;
                end
            end
            default: begin
                st_d.state = DEC_SYNC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy_o = (st_q.state == DEC_SYNC_BUSY);
    assign done_o = st_q.done;

endmodule : dec_sync_tracker

//--- rtl/dec_top.sv
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Internal enable routes output to comparator
// - External enable drives output pin buffer
// - Empty event out when buffer empties
// - Start event moves buffer into data
// - Enable set and clear share bits
// - Enable set: one sets, zero ignored
// - Enable clear bit 0 clears underrun
// - Enable clear bits 2,1 clear sync,empty
// - Buffer move sets empty flag, interrupt
// - Empty cleared by one or buffer write
// - Start event on empty buffer: underrun
// - Underrun cleared only by writing one
// - Busy bit 7 tracks synchronization
// - Left alignment picks bits 15:6 or 9:0
// - Buffer holds next sample for data
module dec_top
    import dec_pkg::*;
#(
    parameter int ADDR_W = 6,
    parameter int SYNC_CYCLES = DEC_SYNC_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Event link
    input wire logic start_event_i,
    output logic empty_event_o,
    // Converter core
    output logic [9:0] conv_value_o,
    output logic conv_start_o,
    output logic internal_output_enable_o,
    output logic external_output_enable_o,
    // Interrupt
    output logic irq_o
);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [2:0] outctl;
        logic [1:0] evctl;
        logic [2:0] inten;
        logic [2:0] flags;
        logic [15:0] data;
        logic [15:0] sample_buffer;
        logic buf_full;
        logic [31:0] rdata;
        logic [9:0] value;
        logic conv_start;
        logic empty_ev;
        logic int_route;
        logic ext_drive;
        logic irq;
    } dec_state_type;

    dec_state_type st_q;
    dec_state_type st_d;

    logic wr_stb;
    logic rd_stb;
    logic [3:0] idx;
    logic sync_start;
    logic sync_busy;
    logic sync_done;

    // ****************************************************
    // Bus front end and crossing tracker
    // ****************************************************
    dec_wb_slave #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .ack_o(ack_o),
        .wr_stb_o(wr_stb),
        .rd_stb_o(rd_stb),
        .idx_o(idx)
    );

    dec_sync_tracker #(
        .SYNC_CYCLES(SYNC_CYCLES)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(sync_start),
        .busy_o(sync_busy),
        .done_o(sync_done)
    );

    // ****************************************************
    // Write decode
    // ****************************************************
    logic wr_lo;
    logic wr_hi;
    logic wr_outctl;
    logic wr_evctl;
    logic wr_inten_clr;
    logic wr_inten_set;
    logic wr_flags;
    logic wr_data;
    logic wr_buf;
    logic [7:0] wb0;

    // Byte lane 0 carries the 8-bit registers
    always_comb begin
        wb0 = dat_i[7:0];
        wr_lo = wr_stb & sel_i[0];
        wr_hi = wr_stb & sel_i[1];
        wr_outctl = wr_lo & (idx == DEC_IDX_OUTPUT_CONTROL);
        wr_evctl = wr_lo & (idx == DEC_IDX_EVENT_CONTROL);
        wr_inten_clr = wr_lo & (idx == DEC_IDX_INT_ENABLE_CLEAR);
        wr_inten_set = wr_lo & (idx == DEC_IDX_INT_ENABLE_SET);
        wr_flags = wr_lo & (idx == DEC_IDX_INT_FLAGS);
        wr_data = (wr_lo | wr_hi) & (idx == DEC_IDX_DATA);
        wr_buf = (wr_lo | wr_hi) & (idx == DEC_IDX_SAMPLE_BUFFER);
    end

    // Synchronized registers restart the crossing tracker; a
    // write while busy restarts the count, so software must
    // wait for busy to clear or the earlier update is lost
    assign sync_start = wr_outctl | wr_data | wr_buf;

    // ****************************************************
    // Conversion path events
    // ****************************************************
    logic ev_taken;
    logic move;
    logic underrun;

    always_comb begin
        ev_taken = start_event_i & st_q.evctl[DEC_BIT_START_IN];
        move = ev_taken & st_q.buf_full;
        underrun = ev_taken & ~st_q.buf_full;
    end

    // Merges a byte-masked write into a 16-bit register
    function automatic logic [15:0] dec_merge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : dec_merge

    // Extracts the 10-bit sample for the chosen alignment
    function automatic logic [9:0] dec_align(
        input logic [15:0] w,
        input logic left
    );
        logic [9:0] res;
        res = left ? w[DEC_LEFT_LSB +: 10] : w[DEC_RIGHT_LSB +: 10];
        return res;
    endfunction : dec_align

    // ****************************************************
    // Interrupt enables
    // ****************************************************
    logic [2:0] inten_n;

    // One shared enable set behind two addresses. The set and
    // clear indices never meet in one cycle, so the order of
    // the two tests below does not matter.
    always_comb begin
        inten_n = st_q.inten;
        if (wr_inten_set) begin
            inten_n = st_q.inten | (wb0[2:0] & DEC_INT_MASK);
        end
        if (wr_inten_clr) begin
            inten_n = st_q.inten & ~(wb0[2:0] & DEC_INT_MASK);
        end
    end

    // ****************************************************
    // Interrupt flags and request
    // ****************************************************
    logic [2:0] set_f;
    logic [2:0] clr_f;
    wire logic [2:0] flags_n;
    wire logic [2:0] pend;

    // Hardware sources on one side, write-one clears on the
    // other; a buffer refill also clears the empty flag
    always_comb begin
        set_f = 3'h0;
        set_f[DEC_BIT_EMPTY] = move;
        set_f[DEC_BIT_UNDERRUN] = underrun;
        set_f[DEC_BIT_SYNC_READY] = sync_done;
        clr_f = 3'h0;
        if (wr_flags) begin
            clr_f = wb0[2:0] & DEC_INT_MASK;
        end
        if (wr_buf) begin
            clr_f[DEC_BIT_EMPTY] = 1'b1;
        end
    end

    // Per flag: a set in the clearing cycle is never lost. The
    // price is a second clear when software races an event,
    // which is cheaper than missing a conversion event.
    for (genvar gi = 0; gi < 3; gi++) begin : g_flag
        assign flags_n[gi] = (st_q.flags[gi] & ~clr_f[gi]) | set_f[gi];
        assign pend[gi] = flags_n[gi] & inten_n[gi];
    end

    // ****************************************************
    // Read-back multiplexer
    // ****************************************************
    logic [31:0] rd_word;

    // Unmapped, write-only and reserved bits read as zero, so
    // a driver probing the map never sees a stale bus value.
    // The word is captured one cycle ahead of ack, so dat_o
    // is settled when the master samples it.
    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            DEC_IDX_OUTPUT_CONTROL: begin
                rd_word[2:0] = st_q.outctl;
            end
            DEC_IDX_EVENT_CONTROL: begin
                rd_word[1:0] = st_q.evctl;
            end
            DEC_IDX_INT_ENABLE_CLEAR,
            DEC_IDX_INT_ENABLE_SET: begin
                rd_word[2:0] = st_q.inten;
            end
            DEC_IDX_INT_FLAGS: begin
                rd_word[2:0] = st_q.flags;
            end
            DEC_IDX_SYNC_STATUS: begin
                rd_word[DEC_BIT_SYNC_BUSY] = sync_busy;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************
    // Next state
    // ****************************************************
    logic [15:0] data_n;

    always_comb begin
        st_d = st_q;
        st_d.conv_start = 1'b0;
        st_d.empty_ev = 1'b0;

        // Plain control registers
        if (wr_outctl) begin
            st_d.outctl = wb0[2:0] & DEC_OUTCTL_MASK;
        end
        if (wr_evctl) begin
            st_d.evctl = wb0[1:0] & DEC_EVCTL_MASK;
        end

        // Enables and flags come from their own logic above, so
        // this process only registers them
        st_d.inten = inten_n;
        st_d.flags = flags_n;

        // Sample path: buffer feeds data on each start event taken by the enabled input that finds it full
        data_n = st_q.data;
        if (move) begin
            data_n = st_q.sample_buffer;
            st_d.buf_full = 1'b0;
            st_d.conv_start = 1'b1;
            st_d.empty_ev = st_q.evctl[DEC_BIT_EMPTY_OUT];
        end
        // A direct write to data wins over the buffered sample
        if (wr_data) begin
            data_n = dec_merge(st_q.data, dat_i, sel_i);
            st_d.conv_start = 1'b1;
        end
        st_d.data = data_n;
        // Refill after the move so the old sample is used first
        if (wr_buf) begin
            st_d.sample_buffer = dec_merge(st_q.sample_buffer, dat_i,
                sel_i);
            st_d.buf_full = 1'b1;
        end

        // Outputs towards the core, all registered
        st_d.value = dec_align(data_n, st_d.outctl[DEC_BIT_LEFT]);
        st_d.int_route = st_d.outctl[DEC_BIT_INT_OUT];
        st_d.ext_drive = st_d.outctl[DEC_BIT_EXT_OUT];
        st_d.irq = |pend;

        // Read data is captured the cycle before ack
        if (rd_stb) begin
            st_d.rdata = rd_word;
        end
    end

    // ****************************************************
    // State register
    // ****************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Ports straight from the state flops: the core and the
    // event system never see a glitch from the bus decode, at
    // the price of one cycle of latency on every path
    assign dat_o = st_q.rdata;
    assign empty_event_o = st_q.empty_ev;
    assign conv_value_o = st_q.value;
    assign conv_start_o = st_q.conv_start;
    assign internal_output_enable_o = st_q.int_route;
    assign external_output_enable_o = st_q.ext_drive;
    assign irq_o = st_q.irq;

endmodule : dec_top

//--- bench/dec_core_model.sv
`timescale 1ns/1ps
module dec_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Core and event side
    input wire logic conv_start_i,
    input wire logic [9:0] conv_value_i,
    input wire logic empty_event_i,
    output logic start_event_o,
    output int starts_o,
    output int empties_o,
    output logic [9:0] sample_o
);
    // Event line idles low from time zero
    initial start_event_o = 1'b0;
    // One-cycle start pulse, launched just after an edge
    task automatic fire();
        @(posedge clk_i);
        start_event_o <= 1'b1;
        @(posedge clk_i);
        start_event_o <= 1'b0;
    endtask : fire
    // Count conversions and keep the sample the core took
    always @(posedge clk_i) begin
        if (rst_i) begin
            starts_o <= 0;
            empties_o <= 0;
        end else begin
            starts_o <= starts_o + int'(conv_start_i);
            empties_o <= empties_o + int'(empty_event_i);
            if (conv_start_i) begin
                sample_o <= conv_value_i;
            end
        end
    end
endmodule : dec_core_model

//--- bench/dec_top_asserts.sv
`timescale 1ns/1ps
module dec_top_asserts
    import dec_pkg::*;
#(
    parameter int ADDR_W = 6,
    parameter int SYNC_CYCLES = DEC_SYNC_CYCLES
) (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Events and interrupt
    input wire logic start_event_i,
    input wire logic empty_event_o,
    input wire logic conv_start_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Accesses as seen at the acknowledging edge
    logic wr_ack;
    logic rd_ack;
    logic [3:0] idx;
    assign wr_ack = ack_o && we_i;
    assign rd_ack = ack_o && !we_i;
    assign idx = adr_i[5:2];

    AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    AST_EMPTY_EV: assert property (empty_event_o |-> conv_start_o
        && $past(start_event_i)) else $error("empty event without move");
    AST_START_CAUSE: assert property (conv_start_o |->
        $past(start_event_i) || $past(wr_ack && idx == DEC_IDX_DATA)
        || $past(wr_ack && idx == DEC_IDX_DATA, 2))
        else $error("conversion started without cause");
    AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr_ack))
        else $error("interrupt dropped without a write");
    AST_STATUS_LOW: assert property (
        rd_ack && idx == DEC_IDX_SYNC_STATUS
        |-> dat_o[6:0] == 7'h00 && dat_o[31:8] == 24'h0)
        else $error("status reads stray bits");
    AST_ENABLE_READ: assert property (rd_ack && idx[3:1] == 3'h2
        |-> dat_o[31:3] == 29'h0) else $error("enable reads stray bits");
    AST_FLAGS_READ: assert property (rd_ack && idx == DEC_IDX_INT_FLAGS
        |-> dat_o[31:3] == 29'h0) else $error("flags read stray bits");
endmodule : dec_top_asserts

bind dec_top dec_top_asserts #(.ADDR_W(ADDR_W), .SYNC_CYCLES(SYNC_CYCLES))
    i_dec_top_asserts (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_o, .ack_o, .start_event_i, .empty_event_o, .conv_start_o, .irq_o);

//--- bench/dec_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module dec_top_tb
    import dec_pkg::*;
;
    // Design ports
    logic clk_i;
    logic rst_i;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [5:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic ack_o;
    logic start_event_i;
    logic empty_event_o;
    logic [9:0] conv_value_o;
    logic conv_start_o;
    logic internal_output_enable_o;
    logic external_output_enable_o;
    logic irq_o;
    // Bench state
    int fails = 0;
    int compares = 0;
    int starts;
    int empties;
    int n0;
    int e0;
    int k;
    logic [9:0] sample;
    logic [9:0] v;
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] seed = 32'h9271fdaf;
    logic left;

    // Sync count of 8, twice the default of 4; the polling loops stay brief
    dec_top #(.SYNC_CYCLES(8)) i_dec_top (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .start_event_i,
        .empty_event_o, .conv_value_o, .conv_start_o,
        .internal_output_enable_o, .external_output_enable_o, .irq_o);
    dec_core_model i_dec_core_model (.clk_i, .rst_i,
        .conv_start_i(conv_start_o), .conv_value_i(conv_value_o),
        .empty_event_i(empty_event_o), .start_event_o(start_event_i),
        .starts_o(starts), .empties_o(empties), .sample_o(sample));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Xorshift source; fixed seed keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Buffer word carrying a sample in the chosen alignment
    function automatic logic [31:0] align(input logic [9:0] s, input logic l);
        return l ? {16'h0, s, 6'h00} : {22'h0, s};
    endfunction : align

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // One classic cycle; all lanes enabled, wait bounded
    task automatic bus(input logic w, input logic [3:0] i,
        input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {i, 2'b00};
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask : bus
    // Poll until the crossing is over, so no update is lost
    task automatic sync_wait();
        int n = 0;
        do begin
            bus(1'b0, DEC_IDX_SYNC_STATUS, 32'h0);
            n++;
        end while (q[DEC_BIT_SYNC_BUSY] !== 1'b0 && n < 20);
        if (n >= 20) begin
            fails++;
            stop_test();
        end
    endtask : sync_wait
    // Start event, settle, then read the flags
    task automatic ev();
        i_dec_core_model.fire();
        repeat (2) @(posedge clk_i);
        bus(1'b0, DEC_IDX_INT_FLAGS, 32'h0);
    endtask : ev

    initial begin
        {cyc_i, stb_i, we_i} = 3'b000;
        adr_i = 6'h00;
        sel_i = 4'hf;
        dat_i = 32'h0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values; index 3 is unmapped
        for (k = 2; k < 8; k++) begin
            bus(1'b0, k[3:0], 32'h0);
            `CHK("reset", 32'h0, q)
        end
        // Enable bits through the set and clear pair
        v = 10'h000;
        for (k = 0; k < 6; k++) begin
            r = rnd();
            bus(1'b1, DEC_IDX_INT_ENABLE_SET, {29'h0, r[2:0]});
            bus(1'b1, DEC_IDX_INT_ENABLE_CLEAR, {29'h0, r[5:3]});
            v = {7'h0, (v[2:0] | r[2:0]) & ~r[5:3]};
            bus(1'b0, DEC_IDX_INT_ENABLE_CLEAR, 32'h0);
            `CHK("en_clr", {22'h0, v}, q)
            bus(1'b0, DEC_IDX_INT_ENABLE_SET, 32'h0);
            `CHK("en_set", {22'h0, v}, q)
        end
        $display("enable test done");
        // Output enables and the crossing, all four pairs
        bus(1'b1, DEC_IDX_INT_ENABLE_CLEAR, 32'h7);
        bus(1'b1, DEC_IDX_INT_ENABLE_SET, 32'h4);
        for (k = 0; k < 4; k++) begin
            r = rnd();
            bus(1'b1, DEC_IDX_OUTPUT_CONTROL, {29'h0, r[0], k[1:0]});
            bus(1'b0, DEC_IDX_SYNC_STATUS, 32'h0);
            `CHK("busy", 32'h80, q)
            sync_wait();
            `CHK("int_out", k[1], internal_output_enable_o)
            `CHK("ext_out", k[0], external_output_enable_o)
            bus(1'b0, DEC_IDX_INT_FLAGS, 32'h0);
            `CHK("sync_flag", 32'h4, q)
            `CHK("irq_sync", 1'b1, irq_o)
            bus(1'b1, DEC_IDX_INT_FLAGS, 32'h4);
            repeat (2) @(posedge clk_i);
            `CHK("irq_low", 1'b0, irq_o)
        end
        left = r[0];
        $display("sync test done");
        // Move, empty event, underrun and flag clearing
        bus(1'b1, DEC_IDX_EVENT_CONTROL, 32'h3);
        bus(1'b1, DEC_IDX_INT_ENABLE_SET, 32'h3);
        for (k = 0; k < 4; k++) begin
            r = rnd();
            v = r[9:0];
            bus(1'b1, DEC_IDX_SAMPLE_BUFFER, align(v, left));
            bus(1'b0, DEC_IDX_INT_FLAGS, 32'h0);
            `CHK("fill", 32'h0, q)
            sync_wait();
            bus(1'b1, DEC_IDX_INT_FLAGS, 32'h4);
            n0 = starts;
            e0 = empties;
            ev();
            `CHK("sample", v, sample)
            `CHK("empty_ev", e0 + 1, empties)
            `CHK("moved", 32'h2, q)
            `CHK("irq_move", 1'b1, irq_o)
            ev();
            `CHK("dry", n0 + 1, starts)
            `CHK("underrun", 32'h3, q)
            bus(1'b1, DEC_IDX_INT_FLAGS, 32'h0);
            bus(1'b1, DEC_IDX_INT_FLAGS, 32'h1);
            bus(1'b0, DEC_IDX_INT_FLAGS, 32'h0);
            `CHK("ur_clr", 32'h2, q)
        end
        // Event output off, masking, then event input off
        bus(1'b1, DEC_IDX_EVENT_CONTROL, 32'h1);
        bus(1'b1, DEC_IDX_SAMPLE_BUFFER, align(v, left));
        sync_wait();
        bus(1'b1, DEC_IDX_INT_FLAGS, 32'h4);
        e0 = empties;
        ev();
        `CHK("ev_off", e0, empties)
        `CHK("started", n0 + 2, starts)
        bus(1'b1, DEC_IDX_INT_ENABLE_CLEAR, 32'h2);
        repeat (2) @(posedge clk_i);
        `CHK("masked", 1'b0, irq_o)
        bus(1'b1, DEC_IDX_EVENT_CONTROL, 32'h0);
        bus(1'b1, DEC_IDX_INT_FLAGS, 32'h7);
        ev();
        `CHK("ignored", n0 + 2, starts)
        `CHK("no_flag", 32'h0, q)
        $display("event test done");
        // Direct data writes in both alignments
        for (k = 0; k < 2; k++) begin
            r = rnd();
            bus(1'b1, DEC_IDX_OUTPUT_CONTROL, {29'h0, k[0], 2'b00});
            sync_wait();
            n0 = starts;
            bus(1'b1, DEC_IDX_DATA, align(r[9:0], k[0]));
            sync_wait();
            `CHK("data_val", r[9:0], conv_value_o)
            `CHK("data_start", n0 + 1, starts)
        end
        $display("data test done");
        stop_test();
    end
endmodule : dec_top_tb
